//--- hdl/image_row_readout_defs.vh
/*
 * constants shared by the row readout control block and its fifo.
 * assumes it is included by bare name from files under hdl/.
 */
`ifndef IMAGE_ROW_READOUT_DEFS_VH
`define IMAGE_ROW_READOUT_DEFS_VH

// width of every active-low handshake pulse, in system clocks
`define RRC_PULSE_CYCLES 2'h2
// row select width and the first column value after a transfer
`define RRC_ROW_W 10
`define RRC_COL_START 7'h00
// reset values of the active-low pulse outputs (idle high)
`define RRC_PULSE_IDLE 1'b1
// controller fsm codes
`define RRC_ST_IDLE 2'h0
`define RRC_ST_CAL 2'h1
`define RRC_ST_CONV 2'h2
// default figures for counts the pins do not fix
`define RRC_CAL_CYCLES 64
`define RRC_GROUPS 128
`define RRC_FIFO_DEPTH 8

`endif

//--- hdl/rrc_fifo.v
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes one clock and an asynchronous active-high clear.
 */
`timescale 1ns/1ps
`default_nettype none

module rrc_fifo #(
   parameter WIDTH = 100,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // clock and clear
   input wire clk_sys_i,
   input wire clr_i,
   // fill side
   input wire in_valid_i,
   input wire [WIDTH-1:0] in_data_i,
   output wire in_ready_o,
   // drain side
   output wire out_valid_o,
   output wire [WIDTH-1:0] out_data_o,
   input wire out_ready_i
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;

   // full and empty come straight from the occupancy count
   assign in_ready_o = (count_reg != DEPTH[AW:0]);
   assign out_valid_o = (count_reg != {(AW+1){1'b0}});
   assign out_data_o = mem_reg[rd_reg];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_ready_i & out_valid_o;

   // pointer wrap works for any depth, not only powers of two
   always @(posedge clk_sys_i or posedge clr_i) begin
      if (clr_i) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                      : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                      : rd_reg + 1'b1;
         end
         if (push & ~pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop & ~push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // storage is not reset; only the pointers give it meaning
   always @(posedge clk_sys_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end

endmodule

`default_nettype wire

//--- hdl/image_row_readout_control.v
/*
 * row readout and converter calibration control of a parallel-output
 * image sensor: calibration handshake, row conversion with optional dark
 * offset, a row fifo, and envelope-framed column output.
 * assumes all inputs are synchronous to clk_sys_i except the row select
 * bus and the two resets; the pixel front end presents the samples of
 * the column group shown on array_col_o in the same cycle.
 */
// Functional notes
// - calibration completion reported by a two-clock low done pulse.
// - dark offset enable low applies a common offset; pin pulled up off.
// - offset is subtracted from the sample before it is quantised.
// - transfer envelope low moves the oldest converted row in the fifo to output.
// - transfer envelope also enables sense amps and restarts column counter.
// - output envelope low advances columns and updates ten ports each edge.
// - output envelope high holds the column counter and data ports; valid goes low.
// - low global clear resets all logic asynchronously; the fifo storage is not reset.
// - row select is 10 bits, bit 9 msb, 0 bottom to 1023 top.
// - row select is used unregistered, at its present level.
// - row processing completion gives a two-cycle low row done pulse.
`timescale 1ns/1ps
`default_nettype none
`include "image_row_readout_defs.vh"

module image_row_readout_control #(
   parameter DATA_W = 10,
   parameter PORTS = 10,
   parameter GROUPS = `RRC_GROUPS,
   parameter COL_W = 7,
   parameter CAL_CYCLES = `RRC_CAL_CYCLES,
   parameter CAL_W = 16,
   parameter FIFO_DEPTH = `RRC_FIFO_DEPTH,
   parameter FIFO_AW = 3
) (
   // clock and resets
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire global_logic_clear_n_i,
   // calibration handshake
   input wire adc_cal_begin_pulse_n_i,
   output wire cal_done_n_o,
   output wire cal_busy_o,
   // row conversion
   input wire row_start_n_i,
   input wire [`RRC_ROW_W-1:0] row_addr_i,
   input wire dark_off_en_n_i,
   input wire [DATA_W-1:0] dark_offset_i,
   input wire [PORTS*DATA_W-1:0] pix_sample_i,
   output wire [COL_W-1:0] array_col_o,
   output wire row_done_n_o,
   output wire [`RRC_ROW_W-1:0] converted_row_o,
   // readout
   input wire row_transfer_envelope_n_i,
   input wire column_out_envelope_n_i,
   output wire sense_amp_en_o,
   output wire [COL_W-1:0] col_count_o,
   output wire [PORTS*DATA_W-1:0] data_port_o,
   output wire data_valid_o
);

   localparam WORD_W = PORTS * DATA_W;
   // controller states, binary encoded
   localparam [1:0] ST_IDLE = `RRC_ST_IDLE;
   localparam [1:0] ST_CAL = `RRC_ST_CAL;
   localparam [1:0] ST_CONV = `RRC_ST_CONV;

   // saturating subtraction of the dark level from one lane
   function [DATA_W-1:0] sub_dark;
      input [DATA_W-1:0] sample;
      input [DATA_W-1:0] offset;
      begin
         sub_dark = (sample > offset) ? sample - offset : {DATA_W{1'b0}};
      end
   endfunction

   // remaining low cycles of an active-low two-cycle pulse
   function [1:0] pulse_next;
      input start;
      input [1:0] left;
      begin
         if (start) begin
            pulse_next = `RRC_PULSE_CYCLES;
         end else if (left != 2'h0) begin
            pulse_next = left - 2'h1;
         end else begin
            pulse_next = 2'h0;
         end
      end
   endfunction

   // either reset clears every register but the fifo storage without waiting for a clock
   wire async_clr = sys_rst_i | ~global_logic_clear_n_i;

   reg [1:0] state_reg;
   reg busy_reg;
   reg [1:0] cal_low_reg;
   reg [CAL_W-1:0] cal_cnt_reg;
   reg [COL_W-1:0] conv_col_reg;
   reg [1:0] cal_pulse_reg;
   reg [1:0] row_pulse_reg;
   reg cal_done_n_reg;
   reg row_done_n_reg;
   reg [`RRC_ROW_W-1:0] conv_row_reg;
   reg armed_reg;
   reg sense_amp_reg;
   reg [COL_W-1:0] col_reg;
   reg [WORD_W-1:0] data_reg;
   reg valid_reg;
   reg [WORD_W-1:0] conv_word;
   reg cal_finish;
   reg row_finish;
   integer i;

   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [WORD_W-1:0] fifo_out_data;
   wire conv_push = (state_reg == ST_CONV);
   wire conv_step = conv_push & fifo_in_ready;
   wire last_conv = (conv_col_reg == GROUPS[COL_W-1:0] - 1'b1);
   wire in_transfer = ~row_transfer_envelope_n_i;
   wire read_step = armed_reg & ~in_transfer & ~column_out_envelope_n_i
                    & fifo_out_valid;
   wire last_read = (col_reg == GROUPS[COL_W-1:0] - 1'b1);

   // offset acts on the front-end level before it becomes a code
   always @* begin
      conv_word = pix_sample_i;
      for (i = 0; i < PORTS; i = i + 1) begin
         if (~dark_off_en_n_i) begin
            conv_word[i*DATA_W +: DATA_W] =
               sub_dark(pix_sample_i[i*DATA_W +: DATA_W],
                        dark_offset_i);
         end
      end
   end

   // converted groups wait here; a full fifo stalls conversion
   rrc_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_row_fifo (
      .clk_sys_i(clk_sys_i),
      .clr_i(async_clr),
      .in_valid_i(conv_push),
      .in_data_i(conv_word),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(fifo_out_valid),
      .out_data_o(fifo_out_data),
      .out_ready_i(read_step)
   );

   // sequencing of calibration and row conversion
   always @(posedge clk_sys_i or posedge async_clr) begin
      if (async_clr) begin
         state_reg <= ST_IDLE;
         busy_reg <= 1'b0;
         cal_low_reg <= 2'h0;
         cal_cnt_reg <= {CAL_W{1'b0}};
         conv_col_reg <= `RRC_COL_START;
         conv_row_reg <= {`RRC_ROW_W{1'b0}};
         cal_finish <= 1'b0;
         row_finish <= 1'b0;
      end else begin
         cal_finish <= 1'b0;
         row_finish <= 1'b0;
         // count the low cycles of the begin pulse, saturating at two
         if (adc_cal_begin_pulse_n_i) begin
            cal_low_reg <= 2'h0;
         end else if (cal_low_reg != `RRC_PULSE_CYCLES) begin
            cal_low_reg <= cal_low_reg + 2'h1;
         end
         case (state_reg)
            ST_IDLE: begin
               // a begin pulse is taken on its second low cycle
               if (~adc_cal_begin_pulse_n_i &&
                   cal_low_reg == `RRC_PULSE_CYCLES - 2'h1) begin
                  state_reg <= ST_CAL;
                  busy_reg <= 1'b1;
                  cal_cnt_reg <= {CAL_W{1'b0}};
               end else if (~row_start_n_i) begin
                  state_reg <= ST_CONV;
                  conv_col_reg <= `RRC_COL_START;
               end
            end
            ST_CAL: begin
               // row starts are ignored until calibration is over
               if (cal_cnt_reg == CAL_CYCLES[CAL_W-1:0] - 1'b1) begin
                  state_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
                  cal_finish <= 1'b1;
               end else begin
                  cal_cnt_reg <= cal_cnt_reg + 1'b1;
               end
            end
            ST_CONV: begin
               if (conv_step) begin
                  conv_col_reg <= conv_col_reg + 1'b1;
                  if (last_conv) begin
                     state_reg <= ST_IDLE;
                     row_finish <= 1'b1;
                     // live bus level, not a copy taken at row start
                     conv_row_reg <= row_addr_i;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               busy_reg <= 1'b0;
            end
         endcase
      end
   end

   // two-cycle active-low completion pulses
   always @(posedge clk_sys_i or posedge async_clr) begin
      if (async_clr) begin
         cal_pulse_reg <= 2'h0;
         row_pulse_reg <= 2'h0;
         cal_done_n_reg <= `RRC_PULSE_IDLE;
         row_done_n_reg <= `RRC_PULSE_IDLE;
      end else begin
         cal_pulse_reg <= pulse_next(cal_finish, cal_pulse_reg);
         row_pulse_reg <= pulse_next(row_finish, row_pulse_reg);
         cal_done_n_reg <= (pulse_next(cal_finish, cal_pulse_reg)
                            == 2'h0);
         row_done_n_reg <= (pulse_next(row_finish, row_pulse_reg)
                            == 2'h0);
      end
   end

   // readout: transfer arms the row, output envelope walks columns
   always @(posedge clk_sys_i or posedge async_clr) begin
      if (async_clr) begin
         armed_reg <= 1'b0;
         sense_amp_reg <= 1'b0;
         col_reg <= `RRC_COL_START;
         data_reg <= {WORD_W{1'b0}};
         valid_reg <= 1'b0;
      end else begin
         if (in_transfer) begin
            // the converted row becomes the output row
            armed_reg <= fifo_out_valid;
            sense_amp_reg <= 1'b1;
            col_reg <= `RRC_COL_START;
            valid_reg <= 1'b0;
         end else if (read_step) begin
            data_reg <= fifo_out_data;
            valid_reg <= 1'b1;
            if (last_read) begin
               armed_reg <= 1'b0;
               sense_amp_reg <= 1'b0;
            end else begin
               col_reg <= col_reg + 1'b1;
            end
         end else begin
            // envelope high: nothing advances, the last word stays
            valid_reg <= 1'b0;
         end
      end
   end

   assign cal_done_n_o = cal_done_n_reg;
   assign cal_busy_o = busy_reg;
   assign array_col_o = conv_col_reg;
   assign row_done_n_o = row_done_n_reg;
   assign converted_row_o = conv_row_reg;
   assign sense_amp_en_o = sense_amp_reg;
   assign col_count_o = col_reg;
   assign data_port_o = data_reg;
   assign data_valid_o = valid_reg;

endmodule

`default_nettype wire

//--- tb/pix_src_model.sv
/* pixel front end model: ten lane samples for the group being converted.
   assumes the group index from the block is settled within the cycle. */
`timescale 1ns/1ps
`default_nettype none
module pix_src_model (
   // group in, samples out
   input wire logic [6:0] col_i,
   output logic [99:0] pix_o
);
   // lane i of group c reads 0x80 + 16c + i, so every lane differs
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         pix_o[10*i +: 10] = 10'h080 + 10'(col_i) * 10'h010 + 10'(i);
      end
   end
endmodule
`default_nettype wire

//--- tb/rrc_chk.sv
/* port checker for the row readout control block.
   assumes it is bound into the block and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module rrc_chk #(parameter GROUPS = 128) (
   // clock and resets
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic global_logic_clear_n_i,
   // handshakes
   input wire logic adc_cal_begin_pulse_n_i,
   input wire logic cal_done_n_o,
   input wire logic cal_busy_o,
   input wire logic row_done_n_o,
   input wire logic [9:0] row_addr_i,
   input wire logic [9:0] converted_row_o,
   // readout
   input wire logic row_transfer_envelope_n_i,
   input wire logic column_out_envelope_n_i,
   input wire logic sense_amp_en_o,
   input wire logic [6:0] col_count_o,
   input wire logic [99:0] data_port_o,
   input wire logic data_valid_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   // either reset silences the checks; the clear check itself is silenced by sys_rst_i only
   default disable iff (sys_rst_i || !global_logic_clear_n_i);
   a_cal_taken: assert property ($rose(cal_busy_o) |->
      !$past(adc_cal_begin_pulse_n_i, 1) &&
      !$past(adc_cal_begin_pulse_n_i, 2)) else $error("early busy");
   a_cal_done_wide: assert property ($fell(cal_done_n_o) |=>
      !cal_done_n_o ##1 cal_done_n_o) else $error("cal done width");
   a_cal_done_time: assert property ($fell(cal_busy_o) |=>
      $fell(cal_done_n_o)) else $error("cal done late");
   a_row_done_wide: assert property ($fell(row_done_n_o) |=>
      !row_done_n_o ##1 row_done_n_o) else $error("row done width");
   a_row_live: assert property ($fell(row_done_n_o) |->
      converted_row_o == row_addr_i) else $error("row address");
   a_xfer_restart: assert property (!row_transfer_envelope_n_i |=>
      col_count_o == 7'h00 && sense_amp_en_o) else $error("no restart");
   a_env_hold: assert property (
      column_out_envelope_n_i && row_transfer_envelope_n_i |=>
      $stable(col_count_o) && $stable(data_port_o) && !data_valid_o)
      else $error("moved while envelope high");
   a_valid_cause: assert property (data_valid_o |->
      !$past(column_out_envelope_n_i) && $past(row_transfer_envelope_n_i))
      else $error("valid without envelope");
   a_col_step: assert property (data_valid_o |->
      col_count_o == $past(col_count_o) + 7'h01 ||
      col_count_o == 7'(GROUPS - 1)) else $error("column step");
   a_clear_async: assert property (disable iff (sys_rst_i)
      !global_logic_clear_n_i |-> cal_done_n_o && row_done_n_o &&
      !sense_amp_en_o && !data_valid_o) else $error("clear ignored");
endmodule
bind image_row_readout_control rrc_chk #(.GROUPS(GROUPS)) u_rrc_chk (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
   .global_logic_clear_n_i(global_logic_clear_n_i),
   .adc_cal_begin_pulse_n_i(adc_cal_begin_pulse_n_i),
   .cal_done_n_o(cal_done_n_o), .cal_busy_o(cal_busy_o),
   .row_done_n_o(row_done_n_o), .row_addr_i(row_addr_i),
   .converted_row_o(converted_row_o),
   .row_transfer_envelope_n_i(row_transfer_envelope_n_i),
   .column_out_envelope_n_i(column_out_envelope_n_i),
   .sense_amp_en_o(sense_amp_en_o), .col_count_o(col_count_o),
   .data_port_o(data_port_o), .data_valid_o(data_valid_o));
`default_nettype wire

//--- tb/tb_image_row_readout_control.sv
/* bench for the row readout control block: calibration, a table of rows
   converted and read back, a full fifo stall, and a mid-run clear.
   assumes the pixel model answers within the cycle. */
`timescale 1ns/1ps
`default_nettype none
module tb_image_row_readout_control;
   localparam int G = 4;
   localparam int CAL = 4;
   logic clk = 0, rst = 1, clr_n = 1, cal_n = 1, start_n = 1, dk_n = 1;
   logic tr_n = 1, oe_n = 1, cal_done_n, busy, row_done_n, sa, dv;
   logic [9:0] addr = 10'h000, off = 10'h000, conv;
   logic [6:0] col, cnt;
   logic [99:0] pix, dp;
   int num_errors = 0, total_checks = 0;
   // row table: address, offset enable (low on), offset
   logic [9:0] t_addr [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
   logic [9:0] t_off [4] = '{10'h000, 10'h010, 10'h3ff, 10'h010};
   logic t_dk [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

   image_row_readout_control #(.CAL_CYCLES(CAL), .GROUPS(G)) DUT (
      .clk_sys_i(clk), .sys_rst_i(rst), .global_logic_clear_n_i(clr_n),
      .adc_cal_begin_pulse_n_i(cal_n), .cal_done_n_o(cal_done_n),
      .cal_busy_o(busy), .row_start_n_i(start_n), .row_addr_i(addr),
      .dark_off_en_n_i(dk_n), .dark_offset_i(off), .pix_sample_i(pix),
      .array_col_o(col), .row_done_n_o(row_done_n),
      .converted_row_o(conv), .row_transfer_envelope_n_i(tr_n),
      .column_out_envelope_n_i(oe_n), .sense_amp_en_o(sa),
      .col_count_o(cnt), .data_port_o(dp), .data_valid_o(dv));
   pix_src_model u_pix (.col_i(col), .pix_o(pix));

   // 4 ns clock
   initial begin
      forever #2 clk = ~clk;
   end

   // offset is taken off each lane before storing, clamped at zero
   function automatic logic [99:0] exp_word(int c, logic dk, logic [9:0] o);
      logic [9:0] s;
      exp_word = '0;
      for (int i = 0; i < 10; i++) begin
         s = 10'(128 + 16 * c + i);
         exp_word[10*i +: 10] = dk ? s : ((s > o) ? s - o : 10'h000);
      end
   endfunction

   task automatic print_verdict;
      if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(string n, logic [99:0] e, logic [99:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask

   // always moves one edge first, so a held flag is not read twice
   task automatic wait_for(ref logic s, input logic v, input int lim);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (s !== v && k < lim);
      if (s !== v) begin
         num_errors++;
         print_verdict();
      end
   endtask

   task automatic start_row(int r);
      @(posedge clk);
      addr <= t_addr[r];
      dk_n <= t_dk[r];
      off <= t_off[r];
      start_n <= 1'b0;
      @(posedge clk);
      start_n <= 1'b1;
   endtask

   // transfer, then pop one row of G words back to back
   task automatic read_row(int r);
      @(posedge clk);
      tr_n <= 1'b0;
      @(posedge clk);
      tr_n <= 1'b1;
      oe_n <= 1'b0;
      for (int c = 0; c < G; c++) begin
         wait_for(dv, 1'b1, 12);
         chk("data", exp_word(c, t_dk[r], t_off[r]), dp);
      end
      @(posedge clk);
      oe_n <= 1'b1;
   endtask

   initial begin
      int n;
      // look after one edge, so the reset has surely taken hold
      @(posedge clk);
      #1;
      chk("reset", 100'(4'b1100), 100'({cal_done_n, row_done_n, sa, dv}));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // calibration first, rows only after its done pulse
      @(posedge clk);
      cal_n <= 1'b0;
      repeat (2) @(posedge clk);
      cal_n <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (cal_done_n !== 1'b0 && n < 50);
      if (cal_done_n !== 1'b0) begin
         num_errors++;
         print_verdict();
      end
      // done falls one edge after the last of CAL busy cycles
      chk("cal_time", 100'(CAL + 1), 100'(n));
      for (int r = 0; r < 4; r++) begin
         start_row(r);
         wait_for(row_done_n, 1'b0, 40);
         chk("conv_row", 100'(t_addr[r]), 100'(conv));
         read_row(r);
      end
      // two rows fill the fifo; the third stalls until a row drains
      start_row(0);
      wait_for(row_done_n, 1'b0, 40);
      start_row(1);
      wait_for(row_done_n, 1'b0, 40);
      start_row(2);
      repeat (12) @(posedge clk);
      chk("stall", 100'(t_addr[1]), 100'(conv));
      read_row(0);
      read_row(1);
      read_row(2);
      chk("late_row", 100'(t_addr[2]), 100'(conv));
      // envelope high mid-row: counter and ports must hold, no valid
      start_row(3);
      wait_for(row_done_n, 1'b0, 40);
      @(posedge clk);
      tr_n <= 1'b0;
      @(posedge clk);
      tr_n <= 1'b1;
      oe_n <= 1'b0;
      wait_for(dv, 1'b1, 12);
      chk("data", exp_word(0, t_dk[3], t_off[3]), dp);
      @(posedge clk);
      oe_n <= 1'b1;
      repeat (3) @(posedge clk);
      oe_n <= 1'b0;
      #1;
      chk("hold_col", 100'(2), 100'(cnt));
      chk("hold_dv", 100'(0), 100'(dv));
      chk("hold_data", exp_word(1, t_dk[3], t_off[3]), dp);
      for (int c = 2; c < G; c++) begin
         wait_for(dv, 1'b1, 12);
         chk("data", exp_word(c, t_dk[3], t_off[3]), dp);
      end
      @(posedge clk);
      oe_n <= 1'b1;
      // clear lands between edges' effects, with no edge in between
      @(posedge clk);
      tr_n <= 1'b0;
      @(posedge clk);
      tr_n <= 1'b1;
      @(posedge clk);
      clr_n <= 1'b0;
      #1;
      chk("clear", 100'h0, 100'({sa, cnt, dv}));
      @(posedge clk);
      clr_n <= 1'b1;
      repeat (2) @(posedge clk);
      print_verdict();
   end
endmodule
`default_nettype wire
